// ===== design/scwt_cfg.svh
//==============================================================
// Contract
// - 32-bit wait counter loads from four byte holds, counts down per unit
// - expiry raises an interrupt and locks receive and transmit
// - uart mode bit clear selects manual counter loading by software
// - manual mode: enable rising edge starts, falling edge stops the count
// - writing byte 2 copies all four timeout bytes into the hold word
// - uart mode and enable set: reload from hold at each start bit
// - automatic reload only if start comes within count plus one units
// - hold word is separate, so writes never disturb the running count
// - software activates; hardware deactivates on removal or supply loss
// - power-up is refused unless a card is present
// - cold start: reset low, io receiving, supply, clock; under 400 clocks
// - watch io for answer between 400 and 40000 clocks after reset release
// - warm reset drives card reset low at least 400 clocks, io receiving
// - supply-loss deactivation uses the same signal order as extraction
// - every enabled interrupt source merges into one active-high line until cleared
// - events during a flag read are deferred until the read ends
// - unit counter makes a single-cycle pulse from the card clock
//==============================================================
`ifndef SCWT_CFG_SVH
`define SCWT_CFG_SVH

`define WT_BYTE_LOAD 2'h2
`define WT_ZERO      32'h0000_0000
`define ETU_ONE      11'h001
`define COLD_RST_CLKS 16'h00c8
`define WARM_RST_CLKS 16'h0191
`define ATR_MIN_CLKS  16'h0190
`define ATR_MAX_CLKS  16'h9c40
`define SEQ_ONE      16'h0001
`define IRQ_WT       0
`define IRQ_CARD     1
`define IRQ_ATR      2
`define IRQ_N        3
`define PIN_CARD     0
`define PIN_SUPPLY   1
`define PIN_IO       2
`define PIN_N        3

`endif

// ===== design/scwt_pkg.sv
package scwt_pkg;

   typedef enum logic [3:0]
   {
      PWR_OFF, PWR_VCC_UP, PWR_CLK_ON, PWR_ATR_WAIT, PWR_ACTIVE,
      PWR_WARM_LOW, PWR_DE_RST, PWR_DE_CLK, PWR_DE_IO, PWR_DE_VCC
   } scwt_pwr_state_t;

   typedef struct packed {
      logic       wr;
      logic [1:0] idx;
      logic [7:0] data;
   } scwt_byte_wr_t;

   typedef struct packed {
      logic vcc_en;
      logic clk;
      logic rst_n;
      logic io_out;
      logic io_oe_n;
   } scwt_card_pins_t;

   typedef struct packed {
      logic [31:0] count;
      logic        running;
      logic        lock;
      logic        card_in;
      logic        atr_seen;
   } scwt_status_t;

endpackage : scwt_pkg

// ===== design/scwt_top.sv
`timescale 1ns/100ps
`include "scwt_cfg.svh"

module scwt_top
#(
   parameter logic [15:0] ATR_MAX_CLKS = `ATR_MAX_CLKS
)
(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    reset_n_i,
   input  wire logic                    soft_reset_i,
   // control
   input  wire logic                    uart_mode_i,
   input  wire logic                    wait_timer_enable_i,
   input  wire logic                    card_det_sense_i,
   input  wire logic [10:0]             etu_div_i,
   input  wire scwt_pkg::scwt_byte_wr_t wt_byte_wr_i,
   input  wire logic                    start_bit_i,
   // activation commands
   input  wire logic                    cold_act_i,
   input  wire logic                    warm_rst_i,
   input  wire logic                    deact_i,
   // interrupt flags
   input  wire logic [`IRQ_N-1:0]       flag_enable_i,
   input  wire logic [`IRQ_N-1:0]       flag_clear_i,
   input  wire logic                    flag_read_i,
   output logic [`IRQ_N-1:0]            flags_o,
   output logic                         irq_o,
   // card pins
   input  wire logic                    card_present_i,
   input  wire logic                    supply_ok_i,
   input  wire logic                    card_io_i,
   output scwt_pkg::scwt_card_pins_t    card_pins_o,
   // unit pulse, lock and status
   output logic                         etu_pulse_o,
   output logic                         lock_o,
   output scwt_pkg::scwt_status_t       status_o
);

   //===========================================================
   // declarations
   logic [`PIN_N-1:0] sync1_r;
   logic [`PIN_N-1:0] sync2_r;
   logic              io_d_r;
   logic              card_in;
   logic              card_in_d_r;
   logic              io_fall;
   logic [7:0]        byte_r [4];
   logic [31:0]       hold_r;
   logic [31:0]       cnt_r;
   logic              run_r;
   logic              lock_r;
   logic              wait_timer_enable_d_r;
   logic              wait_timer_enable_rise;
   logic              wait_timer_enable_fall;
   logic              auto_load;
   logic              expire;
   logic              cclk_r;
   logic              clk_run;
   logic              cc_tick;
   logic [10:0]       etu_cnt_r;
   logic              etu_r;
   logic [15:0]       seq_cnt_r;
   logic              atr_seen_r;
   logic              atr_tmo;
   logic              lost;
   scwt_pkg::scwt_pwr_state_t state_r;
   scwt_pkg::scwt_pwr_state_t state_nxt;
   logic [3:0]        pins_r;
   logic [3:0]        pins_nxt;
   logic [`IRQ_N-1:0] ev;
   logic [`IRQ_N-1:0] flags_r;
   logic [`IRQ_N-1:0] flags_nxt;
   logic [`IRQ_N-1:0] pend_r;
   logic              irq_r;

   function automatic logic byte_hit(input scwt_pkg::scwt_byte_wr_t w,
                                     input logic [1:0] idx);
      byte_hit = w.wr && (w.idx == idx);
   endfunction : byte_hit

   function automatic logic is_deact(input scwt_pkg::scwt_pwr_state_t s);
      is_deact = (s == scwt_pkg::PWR_DE_RST) || (s == scwt_pkg::PWR_DE_CLK)
              || (s == scwt_pkg::PWR_DE_IO) || (s == scwt_pkg::PWR_DE_VCC);
   endfunction : is_deact

   //===========================================================
   // pin synchronisers
   genvar gi;
   generate
      for (gi = 0; gi < `PIN_N; gi++)
      begin : g_sync
         always_ff @(posedge clk_i or negedge reset_n_i)
         begin
            // idle levels: switch and io pulled high, supply off, so
            // no false edge after reset while the sense bit is clear; a closed-switch slot still
            // raises one card flag once the pin settles
            if (!reset_n_i)
            begin
               sync1_r[gi] <= (gi != `PIN_SUPPLY);
               sync2_r[gi] <= (gi != `PIN_SUPPLY);
            end
            else
            begin
               sync1_r[gi] <= (gi == `PIN_CARD) ? card_present_i :
                              (gi == `PIN_SUPPLY) ? supply_ok_i : card_io_i;
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // sense bit clear: pin high means no card
   assign card_in = sync2_r[`PIN_CARD] ^ ~card_det_sense_i;
   assign io_fall = io_d_r & ~sync2_r[`PIN_IO];

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         io_d_r      <= 1'b1;
         card_in_d_r <= 1'b0;
      end
      else
      begin
         io_d_r      <= sync2_r[`PIN_IO];
         card_in_d_r <= card_in;
      end
   end

   //===========================================================
   // timeout bytes and hold word
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_byte
         always_ff @(posedge clk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
               byte_r[gi] <= 8'h00;
            else if (soft_reset_i)
               byte_r[gi] <= 8'h00;
            else if (byte_hit(wt_byte_wr_i, 2'(gi)))
               byte_r[gi] <= wt_byte_wr_i.data;
         end
      end
   endgenerate

   // byte 2 commits the word
   // hold is never the running count, so new limits wait for the next load
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         hold_r <= `WT_ZERO;
      else if (soft_reset_i)
         hold_r <= `WT_ZERO;
      else if (byte_hit(wt_byte_wr_i, `WT_BYTE_LOAD))
         hold_r <= {byte_r[3], wt_byte_wr_i.data, byte_r[1], byte_r[0]};
   end

   //===========================================================
   // waiting-time counter
   assign wait_timer_enable_rise = wait_timer_enable_i & ~wait_timer_enable_d_r;
   assign wait_timer_enable_fall = ~wait_timer_enable_i & wait_timer_enable_d_r;
   // automatic load only in uart mode with enable set
   assign auto_load = uart_mode_i & wait_timer_enable_i & start_bit_i
                    & ~lock_r;
   // zero seen on a pulse means count plus one units passed
   assign expire = run_r & etu_r & (cnt_r == `WT_ZERO) & ~auto_load
                 & ~wait_timer_enable_rise;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         wait_timer_enable_d_r <= 1'b0;
      else
         wait_timer_enable_d_r <= wait_timer_enable_i;
   end

   // count down, hold zero after expiry
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_r <= `WT_ZERO;
         run_r <= 1'b0;
      end
      else if (soft_reset_i)
      begin
         cnt_r <= `WT_ZERO;
         run_r <= 1'b0;
      end
      else if (wait_timer_enable_rise || auto_load)
      begin
         cnt_r <= hold_r;
         run_r <= 1'b1;
      end
      else if (wait_timer_enable_fall || expire)
         run_r <= 1'b0;
      else if (run_r && etu_r)
         cnt_r <= cnt_r - 32'h0000_0001;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         lock_r <= 1'b0;
      else if (soft_reset_i || wait_timer_enable_rise || auto_load)
         lock_r <= 1'b0;
      else if (expire)
         lock_r <= 1'b1;
   end

   //===========================================================
   // card clock and unit counter
   // card clock is half the block clock, so only one tick per two edges
   assign clk_run = (state_r == scwt_pkg::PWR_CLK_ON)
                 || (state_r == scwt_pkg::PWR_ATR_WAIT)
                 || (state_r == scwt_pkg::PWR_ACTIVE)
                 || (state_r == scwt_pkg::PWR_WARM_LOW)
                 || (state_r == scwt_pkg::PWR_DE_RST);
   assign cc_tick = clk_run & ~cclk_r;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cclk_r <= 1'b0;
      else
         cclk_r <= clk_run & ~cclk_r;
   end

   // one-cycle pulse every divisor card clocks
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         etu_cnt_r <= 11'h000;
         etu_r     <= 1'b0;
      end
      else if (soft_reset_i)
      begin
         etu_cnt_r <= 11'h000;
         etu_r     <= 1'b0;
      end
      else
      begin
         etu_r <= 1'b0;
         if (cc_tick)
         begin
            if (etu_cnt_r + `ETU_ONE >= etu_div_i)
            begin
               etu_cnt_r <= 11'h000;
               etu_r     <= 1'b1;
            end
            else
               etu_cnt_r <= etu_cnt_r + `ETU_ONE;
         end
      end
   end

   //===========================================================
   // power sequencer
   assign lost = ~sync2_r[`PIN_SUPPLY] & (state_r != scwt_pkg::PWR_OFF)
               & (state_r != scwt_pkg::PWR_VCC_UP);
   assign atr_tmo = (state_r == scwt_pkg::PWR_ATR_WAIT) & cc_tick
                  & (seq_cnt_r == ATR_MAX_CLKS - `SEQ_ONE) & ~io_fall;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         scwt_pkg::PWR_OFF:
            if (cold_act_i && card_in)
               state_nxt = scwt_pkg::PWR_VCC_UP;
         scwt_pkg::PWR_VCC_UP:
            if (sync2_r[`PIN_SUPPLY])
               state_nxt = scwt_pkg::PWR_CLK_ON;
         // reset low for fewer than 400 clocks
         scwt_pkg::PWR_CLK_ON:
            if (cc_tick && seq_cnt_r == `COLD_RST_CLKS - `SEQ_ONE)
               state_nxt = scwt_pkg::PWR_ATR_WAIT;
         // answer accepted only inside the window
         scwt_pkg::PWR_ATR_WAIT:
            if ((io_fall && seq_cnt_r >= `ATR_MIN_CLKS) || atr_tmo)
               state_nxt = scwt_pkg::PWR_ACTIVE;
         scwt_pkg::PWR_ACTIVE:
            if (warm_rst_i)
               state_nxt = scwt_pkg::PWR_WARM_LOW;
         // warm reset low at least 400 clocks
         scwt_pkg::PWR_WARM_LOW:
            if (cc_tick && seq_cnt_r == `WARM_RST_CLKS - `SEQ_ONE)
               state_nxt = scwt_pkg::PWR_ATR_WAIT;
         scwt_pkg::PWR_DE_RST:
            if (cc_tick)
               state_nxt = scwt_pkg::PWR_DE_CLK;
         scwt_pkg::PWR_DE_CLK:
            state_nxt = scwt_pkg::PWR_DE_IO;
         scwt_pkg::PWR_DE_IO:
            state_nxt = scwt_pkg::PWR_DE_VCC;
         scwt_pkg::PWR_DE_VCC:
            state_nxt = scwt_pkg::PWR_OFF;
         default:
            state_nxt = scwt_pkg::PWR_OFF;
      endcase
      // removal, supply loss or command share one order
      if (state_r != scwt_pkg::PWR_OFF && !is_deact(state_r)
          && (deact_i || !card_in || lost))
         state_nxt = scwt_pkg::PWR_DE_RST;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r   <= scwt_pkg::PWR_OFF;
         seq_cnt_r <= 16'h0000;
      end
      else if (soft_reset_i)
      begin
         state_r   <= scwt_pkg::PWR_OFF;
         seq_cnt_r <= 16'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt != state_r)
            seq_cnt_r <= 16'h0000;
         else if (cc_tick)
            seq_cnt_r <= seq_cnt_r + `SEQ_ONE;
      end
   end

   // pins: vcc_en, rst_n, io_out, io_oe_n
   always_comb
   begin
      pins_nxt[3] = (state_nxt != scwt_pkg::PWR_OFF)
                 && (state_nxt != scwt_pkg::PWR_DE_VCC);
      pins_nxt[2] = (state_nxt == scwt_pkg::PWR_ATR_WAIT)
                 || (state_nxt == scwt_pkg::PWR_ACTIVE);
      pins_nxt[1] = 1'b0;
      pins_nxt[0] = (state_nxt != scwt_pkg::PWR_DE_IO)
                 && (state_nxt != scwt_pkg::PWR_DE_VCC);
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pins_r <= 4'h1;
      else
         pins_r <= pins_nxt;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         atr_seen_r <= 1'b0;
      else if (soft_reset_i || state_r != scwt_pkg::PWR_ATR_WAIT
               && state_nxt == scwt_pkg::PWR_ATR_WAIT)
         atr_seen_r <= 1'b0;
      else if (state_r == scwt_pkg::PWR_ATR_WAIT && io_fall
               && seq_cnt_r >= `ATR_MIN_CLKS)
         atr_seen_r <= 1'b1;
   end

   //===========================================================
   // interrupt flags
   assign ev[`IRQ_WT]   = expire;
   assign ev[`IRQ_CARD] = card_in ^ card_in_d_r;
   assign ev[`IRQ_ATR]  = atr_tmo;

   // set wins over clear; sets wait out a read
   always_comb
   begin
      flags_nxt = flags_r & ~flag_clear_i;
      if (!flag_read_i)
         flags_nxt = flags_nxt | ev | pend_r;
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         flags_r <= 3'h0;
         pend_r  <= 3'h0;
         irq_r   <= 1'b0;
      end
      else if (soft_reset_i)
      begin
         flags_r <= 3'h0;
         pend_r  <= 3'h0;
         irq_r   <= 1'b0;
      end
      else
      begin
         flags_r <= flags_nxt;
         pend_r  <= flag_read_i ? (pend_r | ev) : 3'h0;
         irq_r   <= |(flags_nxt & flag_enable_i);
      end
   end

   //===========================================================
   // outputs
   assign flags_o     = flags_r;
   assign irq_o       = irq_r;
   assign etu_pulse_o = etu_r;
   assign lock_o      = lock_r;
   assign card_pins_o = '{vcc_en: pins_r[3], clk: cclk_r,
                          rst_n: pins_r[2], io_out: pins_r[1],
                          io_oe_n: pins_r[0]};
   assign status_o    = '{count: cnt_r, running: run_r, lock: lock_r,
                          card_in: card_in, atr_seen: atr_seen_r};

   //===========================================================
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i || soft_reset_i);

   wt_count_down_a: assert property (run_r && etu_r && cnt_r != `WT_ZERO
      && !wait_timer_enable_rise && !auto_load && !wait_timer_enable_fall |=>
      cnt_r == $past(cnt_r) - 32'h0000_0001)
      else $error("wait count did not step down");
   wt_expire_lock_a: assert property (expire |=> lock_r && !run_r
      ##1 lock_r)
      else $error("expiry did not lock");
   hold_load_a: assert property (byte_hit(wt_byte_wr_i, `WT_BYTE_LOAD)
      |=> hold_r[23:16] == $past(wt_byte_wr_i.data))
      else $error("hold word not loaded");
   manual_start_a: assert property (!uart_mode_i && wait_timer_enable_rise
      |=> run_r && cnt_r == $past(hold_r))
      else $error("enable edge did not start");
   auto_reload_a: assert property (auto_load
      |=> cnt_r == $past(hold_r) && !lock_r)
      else $error("start bit did not reload");
   hold_zero_a: assert property (lock_r && !wait_timer_enable_rise && !auto_load
      |=> cnt_r == `WT_ZERO && lock_r && !expire)
      else $error("expired counter moved");
   no_card_off_a: assert property (state_r == scwt_pkg::PWR_OFF
      && !card_in |=> !pins_r[3])
      else $error("powered without card");
   cold_pins_a: assert property (state_r == scwt_pkg::PWR_CLK_ON
      |-> pins_r[3] && !pins_r[2] && pins_r[0])
      else $error("cold start pins wrong");
   atr_early_a: assert property (state_r == scwt_pkg::PWR_ATR_WAIT
      && io_fall && seq_cnt_r < `ATR_MIN_CLKS && !deact_i && card_in
      && !lost |=> state_r == scwt_pkg::PWR_ATR_WAIT)
      else $error("answer taken too early");
   read_defer_a: assert property (flag_read_i
      |=> flags_r == ($past(flags_r) & ~$past(flag_clear_i)))
      else $error("flag set during read");

endmodule : scwt_top

// ===== test/scwt_card_model.sv
`timescale 1ns/100ps

module scwt_card_model
#(
   parameter int ANSWER_CLKS = 500
)
(
   // clock
   input  wire logic                      clk_i,
   // card slot and terminal pins
   input  wire logic                      inserted_i,
   input  wire scwt_pkg::scwt_card_pins_t pins_i,
   // sensed by the terminal
   output logic                           card_present_o,
   output logic                           supply_ok_o,
   output logic                           card_io_o
);
   //==============================
   // supply, presence and answer
   int   n_clk = 0;
   logic clk_q = 1'b0;
   logic answer;

   // switch open with no card: pin pulled high, low with a card in
   assign card_present_o = ~inserted_i;

   initial supply_ok_o = 1'b0;
   always @(posedge clk_i)
      supply_ok_o <= pins_i.vcc_en & inserted_i;

   always @(posedge clk_i)
   begin
      clk_q <= pins_i.clk;
      if (!pins_i.rst_n || !pins_i.vcc_en)
         n_clk <= 0;
      else if (pins_i.clk && !clk_q && n_clk < ANSWER_CLKS + 20)
         n_clk <= n_clk + 1;
   end
   assign answer = !(n_clk >= ANSWER_CLKS && n_clk < ANSWER_CLKS + 10);

   // pulled-up line: released io reads high, never a stale value
   assign card_io_o = (answer | ~inserted_i)
                    & (pins_i.io_oe_n | pins_i.io_out);
endmodule : scwt_card_model

// ===== test/tb_top.sv
`timescale 1ns/100ps
`include "scwt_cfg.svh"

module tb_top;
   //==============================
   // stimulus and observed signals
   logic                      clk_i = 1'b0;
   logic                      reset_n_i = 1'b0;
   logic                      soft_reset_i = 1'b0;
   logic                      uart_mode_i = 1'b0;
   logic                      wait_timer_enable_i = 1'b0;
   logic                      cold_act_i = 1'b0;
   logic                      warm_rst_i = 1'b0;
   logic                      start_bit_i = 1'b0;
   logic                      flag_read_i = 1'b0;
   logic                      inserted = 1'b0;
   logic                      cclk_q = 1'b0;
   logic [`IRQ_N-1:0]         flag_enable_i = 3'h7;
   logic [`IRQ_N-1:0]         flag_clear_i = 3'h0;
   scwt_pkg::scwt_byte_wr_t   wt_byte_wr_i = '0;
   logic [`IRQ_N-1:0]         flags_o;
   logic                      irq_o;
   logic                      etu_pulse_o;
   logic                      lock_o;
   logic                      card_present_i;
   logic                      supply_ok_i;
   logic                      card_io_i;
   scwt_pkg::scwt_card_pins_t card_pins_o;
   scwt_pkg::scwt_status_t    status_o;
   int                        n_mismatch = 0;
   int                        checked = 0;
   int                        n;
   logic [31:0]               c;

   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) cclk_q <= card_pins_o.clk;

   //==============================
   // design and card
   // small answer limit keeps the run short
   scwt_top #(.ATR_MAX_CLKS(16'h0800)) DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .soft_reset_i(soft_reset_i),
      .uart_mode_i(uart_mode_i), .wait_timer_enable_i(wait_timer_enable_i),
      .card_det_sense_i(1'b0), .etu_div_i(11'h002),
      .wt_byte_wr_i(wt_byte_wr_i), .start_bit_i(start_bit_i),
      .cold_act_i(cold_act_i), .warm_rst_i(warm_rst_i), .deact_i(1'b0),
      .flag_enable_i(flag_enable_i), .flag_clear_i(flag_clear_i),
      .flag_read_i(flag_read_i), .flags_o(flags_o), .irq_o(irq_o),
      .card_present_i(card_present_i), .supply_ok_i(supply_ok_i),
      .card_io_i(card_io_i), .card_pins_o(card_pins_o),
      .etu_pulse_o(etu_pulse_o), .lock_o(lock_o), .status_o(status_o));

   scwt_card_model CARD (
      .clk_i(clk_i), .inserted_i(inserted), .pins_i(card_pins_o),
      .card_present_o(card_present_i), .supply_ok_o(supply_ok_i),
      .card_io_o(card_io_i));

   //==============================
   // tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : tick

   task automatic wr_byte(input logic [1:0] idx, input logic [7:0] d);
      @(posedge clk_i);
      wt_byte_wr_i <= '{wr: 1'b1, idx: idx, data: d};
      @(posedge clk_i);
      wt_byte_wr_i <= '0;
   endtask : wr_byte

   // byte 2 last: it is the one that copies all four into the hold word
   task automatic load_word(input logic [31:0] w);
      wr_byte(2'h0, w[7:0]);
      wr_byte(2'h1, w[15:8]);
      wr_byte(2'h3, w[31:24]);
      wr_byte(2'h2, w[23:16]);
      tick(1);
   endtask : load_word

   task automatic set_wait_timer_enable(input logic v);
      @(posedge clk_i) wait_timer_enable_i <= v;
      tick(1);
   endtask : set_wait_timer_enable

   task automatic wait_lock(output int np);
      np = 0;
      for (int i = 0; i < 200 && lock_o !== 1'b1; i++)
      begin
         if (etu_pulse_o === 1'b1)
            np++;
         tick(1);
      end
   endtask : wait_lock

   task automatic count_rst_low(output int nc);
      nc = 0;
      for (int i = 0; i < 3000 && card_pins_o.rst_n !== 1'b1; i++)
      begin
         tick(1);
         if (card_pins_o.clk & ~cclk_q)
            nc++;
      end
   endtask : count_rst_low

   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   //==============================
   // watchdog, far above the expected run of some 4000 cycles
   initial
   begin
      repeat (30000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end

   //==============================
   // tests
   initial
   begin
      tick(2);
      reset_n_i <= 1'b1;
      tick(1);
      check({flags_o, irq_o, lock_o}, 5'h00);
      check({card_pins_o.vcc_en, card_pins_o.io_oe_n}, 2'b01);
      @(posedge clk_i) cold_act_i <= 1'b1;
      @(posedge clk_i) cold_act_i <= 1'b0;
      tick(20);
      check(card_pins_o.vcc_en, 1'b0);
      @(posedge clk_i) inserted <= 1'b1;
      tick(10);
      check(status_o.card_in, 1'b1);
      @(posedge clk_i) cold_act_i <= 1'b1;
      @(posedge clk_i) cold_act_i <= 1'b0;
      count_rst_low(n);
      check(n > 0 && n < 400, 1'b1);
      check(card_pins_o.io_oe_n, 1'b1);
      for (int i = 0; i < 3000 && status_o.atr_seen !== 1'b1; i++)
         tick(1);
      check({status_o.atr_seen, flags_o[`IRQ_ATR]}, 2'b10);
      @(posedge clk_i) warm_rst_i <= 1'b1;
      @(posedge clk_i) warm_rst_i <= 1'b0;
      tick(0);
      count_rst_low(n);
      check(n >= 400, 1'b1);
      tick(1500);
      check(flags_o[`IRQ_ATR], 1'b0);
      @(posedge clk_i) flag_clear_i <= 3'h7;
      @(posedge clk_i) flag_clear_i <= 3'h0;
      tick(2);
      check(irq_o, 1'b0);
      load_word(32'h1234_5678);
      set_wait_timer_enable(1'b1);
      check(status_o.count, 32'h1234_5678);
      tick(40);
      c = status_o.count;
      check(c < 32'h1234_5678 && c > 32'h1234_5600, 1'b1);
      load_word(32'h0000_0003);
      check(status_o.count > 32'h1234_5600, 1'b1);
      set_wait_timer_enable(1'b0);
      c = status_o.count;
      tick(20);
      check(status_o.count, c);
      check(status_o.running, 1'b0);
      set_wait_timer_enable(1'b1);
      check(status_o.count, 32'h0000_0003);
      wait_lock(n);
      check(n >= 4 && n <= 5, 1'b1);
      check({lock_o, flags_o[`IRQ_WT], irq_o}, 3'b111);
      tick(30);
      check(status_o.count, 32'h0);
      @(posedge clk_i) flag_clear_i <= 3'h1;
      @(posedge clk_i) flag_clear_i <= 3'h0;
      tick(30);
      check({lock_o, flags_o[`IRQ_WT]}, 2'b10);
      set_wait_timer_enable(1'b0);
      wr_byte(2'h2, 8'h00);
      set_wait_timer_enable(1'b1);
      check({lock_o, status_o.count[7:0]}, 9'h003);
      @(posedge clk_i) flag_read_i <= 1'b1;
      wait_lock(n);
      tick(5);
      check(flags_o[`IRQ_WT], 1'b0);
      @(posedge clk_i) flag_read_i <= 1'b0;
      tick(2);
      check({flags_o[`IRQ_WT], irq_o}, 2'b11);
      @(posedge clk_i) uart_mode_i <= 1'b1;
      // enable dropped around the new count
      set_wait_timer_enable(1'b0);
      load_word(32'h0000_0014);
      set_wait_timer_enable(1'b1);
      // next limit written while the count runs
      load_word(32'h0000_0018);
      check(status_o.count < 32'h0000_0014, 1'b1);
      @(posedge clk_i) start_bit_i <= 1'b1;
      @(posedge clk_i) start_bit_i <= 1'b0;
      tick(0);
      check(status_o.count, 32'h0000_0018);
      wait_lock(n);
      @(posedge clk_i) start_bit_i <= 1'b1;
      @(posedge clk_i) start_bit_i <= 1'b0;
      tick(2);
      check({lock_o, status_o.count[7:0]}, 9'h100);
      @(posedge clk_i) flag_enable_i <= 3'h6;
      tick(2);
      check({irq_o, flags_o[`IRQ_WT], status_o.lock}, 3'b011);
      @(posedge clk_i) inserted <= 1'b0;
      n = 0;
      for (int i = 0; i < 200 && card_pins_o.vcc_en !== 1'b0; i++)
      begin
         tick(1);
         if (card_pins_o.vcc_en === 1'b0 && card_pins_o.rst_n !== 1'b0)
            n++;
      end
      check(n, 0);
      check({card_pins_o.vcc_en, card_pins_o.rst_n}, 2'b00);
      @(posedge clk_i) soft_reset_i <= 1'b1;
      @(posedge clk_i) soft_reset_i <= 1'b0;
      tick(2);
      check(lock_o, 1'b0);
      final_report();
   end
endmodule : tb_top
